// >>> design/pfp_pkg.sv
// constants and types shared by the parallel flash programming port
package pfp_pkg;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int MODE_W = 4;
	localparam int ADDR_W = 32;
	localparam int FIFO_DEPTH = 4;
	// pin synchroniser vector layout
	localparam int PIN_W = 28;
	localparam int PIN_DATA_LSB = 0;
	localparam int PIN_MODE_LSB = 16;
	localparam int PIN_BYTE_WIDE = 20;
	localparam int PIN_MAIN_CLK = 21;
	localparam int PIN_OE_N = 22;
	localparam int PIN_CMD_N = 23;
	localparam int PIN_EN_C = 24;
	localparam int PIN_EN_B = 25;
	localparam int PIN_EN_A = 26;
	localparam int PIN_TEST = 27;
	// pins float high through pull-ups, so the synchronisers reset to ones;
	// the main clock pin has no pull-up and is usually grounded, so it resets low
	localparam logic [PIN_W-1:0] PIN_RESET = 28'hfdfffff;
	// word kinds on the mode input
	localparam logic [MODE_W-1:0] command_word_mode = 4'h0;
	localparam logic [MODE_W-1:0] address_byte_low_mode = 4'h1;
	localparam logic [MODE_W-1:0] ADDR_BYTE1_MODE = 4'h2;
	localparam logic [MODE_W-1:0] ADDR_BYTE2_MODE = 4'h3;
	localparam logic [MODE_W-1:0] ADDR_BYTE3_MODE = 4'h4;
	localparam logic [MODE_W-1:0] DATA_WORD_MODE = 4'h5;
	// command codes
	localparam logic [DATA_W-1:0] READ_FLASH_CMD = 16'h0011;
	localparam logic [DATA_W-1:0] WRITE_PAGE_CMD = 16'h0012;
	localparam logic [DATA_W-1:0] WRITE_PAGE_LOCK_CMD = 16'h0022;
	localparam logic [DATA_W-1:0] ERASE_WRITE_PAGE_CMD = 16'h0032;
	localparam logic [DATA_W-1:0] ERASE_WRITE_LOCK_CMD = 16'h0042;
	localparam logic [DATA_W-1:0] erase_all_cmd = 16'h0013;
	localparam logic [DATA_W-1:0] set_lock_cmd = 16'h0014;
	localparam logic [DATA_W-1:0] CLEAR_LOCK_CMD = 16'h0024;
	localparam logic [DATA_W-1:0] READ_LOCK_CMD = 16'h0015;
	localparam logic [DATA_W-1:0] SET_NVM_BIT_CMD = 16'h0034;
	localparam logic [DATA_W-1:0] CLEAR_NVM_BIT_CMD = 16'h0044;
	localparam logic [DATA_W-1:0] READ_NVM_BIT_CMD = 16'h0025;
	localparam logic [DATA_W-1:0] SET_SECURE_CMD = 16'h0054;
	localparam logic [DATA_W-1:0] READ_SECURE_CMD = 16'h0035;
	localparam logic [DATA_W-1:0] WRITE_MEMORY_CMD = 16'h001f;
	localparam logic [DATA_W-1:0] SELECT_CTRL_CMD = 16'h0016;
	localparam logic [DATA_W-1:0] get_version_cmd = 16'h001e;
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_IDLE,
		ST_EXEC,
		ST_RD_OE,
		ST_RD_DRIVE,
		ST_RD_HOLD,
		ST_RD_REL,
		ST_WAIT_STROBE
	} pfp_state_t;
endpackage

// >>> design/pfp_port.sv
// parallel flash programming port: pin handshake, word decode and read-data fifo

// fifo between the flash read path and the pin side
module pfp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_flush,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] count_reg;
	logic [PTR_W:0] count_next;
	logic push;
	logic pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = i_out_ready && o_out_valid;
	assign o_out_data = mem_reg[rd_ptr_reg];

	always_comb
	begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset || i_flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			o_in_ready <= (count_next != (PTR_W + 1)'(DEPTH));
			o_out_valid <= (count_next != '0);
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= i_in_data;
	end
endmodule

module pfp_port (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_test_select,
	input wire logic i_prog_enable_a,
	input wire logic i_prog_enable_b,
	input wire logic i_prog_enable_c,
	input wire logic i_main_clock_input,
	input wire logic i_byte_wide,
	input wire logic i_command_strobe_n,
	input wire logic i_output_enable_n,
	input wire logic [pfp_pkg::MODE_W-1:0] i_word_kind_select,
	input wire logic [pfp_pkg::DATA_W-1:0] i_prog_data_bus,
	output logic [pfp_pkg::DATA_W-1:0] o_prog_data_bus,
	output logic o_prog_data_bus_oe,
	output logic o_port_ready,
	output logic o_port_ready_oe,
	output logic o_data_valid_n,
	output logic o_data_valid_n_oe,
	output logic o_ext_clock_sel,
	output logic o_cmd_valid,
	output logic [pfp_pkg::DATA_W-1:0] o_cmd_code,
	output logic [pfp_pkg::ADDR_W-1:0] o_cmd_addr,
	output logic [pfp_pkg::DATA_W-1:0] o_cmd_data,
	input wire logic i_cmd_done,
	input wire logic i_rd_valid,
	input wire logic [pfp_pkg::DATA_W-1:0] i_rd_data,
	output logic o_rd_ready
);
	logic [pfp_pkg::PIN_W-1:0] pin_meta_reg;
	logic [pfp_pkg::PIN_W-1:0] pin_sync_reg;
	logic clk_pin_prev_reg;
	pfp_pkg::pfp_state_t state_reg;
	logic test_mode;
	logic cmd_n_s;
	logic oe_n_s;
	logic [pfp_pkg::MODE_W-1:0] kind_s;
	logic [pfp_pkg::DATA_W-1:0] data_s;
	logic latch;
	logic read_kind;
	logic byte_wide_reg;
	logic first_cmd_seen_reg;
	logic [pfp_pkg::DATA_W-1:0] cmd_reg;
	logic [pfp_pkg::ADDR_W-1:0] addr_reg;
	logic fifo_flush;
	logic fifo_valid;
	logic fifo_pop;
	logic [pfp_pkg::DATA_W-1:0] fifo_data;

	// every pin passes two flip-flops; only the second is read
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			pin_meta_reg <= pfp_pkg::PIN_RESET;
			pin_sync_reg <= pfp_pkg::PIN_RESET;
		end
		else
		begin
			pin_meta_reg <= {i_test_select, i_prog_enable_a, i_prog_enable_b, i_prog_enable_c,
				i_command_strobe_n, i_output_enable_n, i_main_clock_input, i_byte_wide,
				i_word_kind_select, i_prog_data_bus};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign test_mode = pin_sync_reg[pfp_pkg::PIN_TEST] && pin_sync_reg[pfp_pkg::PIN_EN_A]
		&& pin_sync_reg[pfp_pkg::PIN_EN_B] && !pin_sync_reg[pfp_pkg::PIN_EN_C];
	assign cmd_n_s = pin_sync_reg[pfp_pkg::PIN_CMD_N];
	assign oe_n_s = pin_sync_reg[pfp_pkg::PIN_OE_N];
	assign kind_s = pin_sync_reg[pfp_pkg::PIN_MODE_LSB +: pfp_pkg::MODE_W];
	// narrow variants see only the low byte
	assign data_s = byte_wide_reg ? {8'h00, pin_sync_reg[pfp_pkg::PIN_DATA_LSB +: pfp_pkg::BYTE_W]}
		: pin_sync_reg[pfp_pkg::PIN_DATA_LSB +: pfp_pkg::DATA_W];
	assign latch = (state_reg == pfp_pkg::ST_IDLE) && test_mode && !cmd_n_s;
	assign read_kind = (cmd_reg == pfp_pkg::READ_FLASH_CMD) || (cmd_reg == pfp_pkg::READ_LOCK_CMD)
		|| (cmd_reg == pfp_pkg::READ_NVM_BIT_CMD) || (cmd_reg == pfp_pkg::READ_SECURE_CMD)
		|| (cmd_reg == pfp_pkg::get_version_cmd);
	assign fifo_pop = (state_reg == pfp_pkg::ST_RD_OE) && !oe_n_s && fifo_valid;
	assign fifo_flush = latch && (kind_s == pfp_pkg::command_word_mode);

	// width strap is taken while the port is off, never under reset
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			byte_wide_reg <= 1'b0;
		else if (state_reg == pfp_pkg::ST_OFF)
			byte_wide_reg <= pin_sync_reg[pfp_pkg::PIN_BYTE_WIDE];
	end

	// toggling on the main clock pin before the first command selects it
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			// matches the synchroniser reset so a grounded pin shows no false edge
			clk_pin_prev_reg <= 1'b0;
			first_cmd_seen_reg <= 1'b0;
			o_ext_clock_sel <= 1'b0;
		end
		else
		begin
			clk_pin_prev_reg <= pin_sync_reg[pfp_pkg::PIN_MAIN_CLK];
			if (latch)
				first_cmd_seen_reg <= 1'b1;
			if (!first_cmd_seen_reg && !latch
				&& (clk_pin_prev_reg != pin_sync_reg[pfp_pkg::PIN_MAIN_CLK]))
				o_ext_clock_sel <= 1'b1;
		end
	end

	// command and address registers, selected by word kind
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			cmd_reg <= pfp_pkg::CMD_RESET;
			addr_reg <= pfp_pkg::ADDR_RESET;
		end
		else if (latch)
		begin
			case (kind_s)
				pfp_pkg::command_word_mode: cmd_reg <= data_s;
				pfp_pkg::address_byte_low_mode: addr_reg[7:0] <= data_s[7:0];
				pfp_pkg::ADDR_BYTE1_MODE: addr_reg[15:8] <= data_s[7:0];
				pfp_pkg::ADDR_BYTE2_MODE: addr_reg[23:16] <= data_s[7:0];
				pfp_pkg::ADDR_BYTE3_MODE: addr_reg[31:24] <= data_s[7:0];
				pfp_pkg::DATA_WORD_MODE: addr_reg <= addr_reg + 1'b1;
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// request towards the flash controller
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_cmd_valid <= 1'b0;
			o_cmd_code <= pfp_pkg::CMD_RESET;
			o_cmd_addr <= pfp_pkg::ADDR_RESET;
			o_cmd_data <= '0;
		end
		else
		begin
			o_cmd_valid <= 1'b0;
			if (latch && (kind_s == pfp_pkg::command_word_mode)
				&& !((data_s == pfp_pkg::READ_FLASH_CMD) || (data_s == pfp_pkg::READ_LOCK_CMD)
				|| (data_s == pfp_pkg::READ_NVM_BIT_CMD) || (data_s == pfp_pkg::READ_SECURE_CMD)
				|| (data_s == pfp_pkg::get_version_cmd)))
			begin
				o_cmd_valid <= 1'b1;
				o_cmd_code <= data_s;
				o_cmd_addr <= addr_reg;
				o_cmd_data <= '0;
			end
			else if (latch && (kind_s == pfp_pkg::DATA_WORD_MODE))
			begin
				o_cmd_valid <= 1'b1;
				o_cmd_code <= cmd_reg;
				o_cmd_addr <= addr_reg;
				o_cmd_data <= data_s;
			end
		end
	end

	// handshake sequencer
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			state_reg <= pfp_pkg::ST_OFF;
		else if (!test_mode)
			state_reg <= pfp_pkg::ST_OFF;
		else
		begin
			case (state_reg)
				pfp_pkg::ST_OFF: state_reg <= pfp_pkg::ST_WAIT_STROBE;
				pfp_pkg::ST_IDLE:
					if (latch)
					begin
						if (kind_s == pfp_pkg::DATA_WORD_MODE)
							state_reg <= read_kind ? pfp_pkg::ST_RD_OE : pfp_pkg::ST_EXEC;
						else if (o_cmd_valid_next_cmd(kind_s, data_s))
							state_reg <= pfp_pkg::ST_EXEC;
						else
							state_reg <= pfp_pkg::ST_WAIT_STROBE;
					end
				pfp_pkg::ST_EXEC:
					if (i_cmd_done)
						state_reg <= pfp_pkg::ST_WAIT_STROBE;
				pfp_pkg::ST_RD_OE:
					if (fifo_pop)
						state_reg <= pfp_pkg::ST_RD_DRIVE;
				pfp_pkg::ST_RD_DRIVE: state_reg <= pfp_pkg::ST_RD_HOLD;
				pfp_pkg::ST_RD_HOLD:
					if (oe_n_s)
						state_reg <= pfp_pkg::ST_RD_REL;
				pfp_pkg::ST_RD_REL: state_reg <= pfp_pkg::ST_WAIT_STROBE;
				pfp_pkg::ST_WAIT_STROBE:
					if (cmd_n_s)
						state_reg <= pfp_pkg::ST_IDLE;
				default: state_reg <= pfp_pkg::ST_OFF;
			endcase
		end
	end

	// a command word other than a read kind runs on the controller
	function automatic logic o_cmd_valid_next_cmd(input logic [pfp_pkg::MODE_W-1:0] kind,
		input logic [pfp_pkg::DATA_W-1:0] word);
		o_cmd_valid_next_cmd = (kind == pfp_pkg::command_word_mode)
			&& !((word == pfp_pkg::READ_FLASH_CMD) || (word == pfp_pkg::READ_LOCK_CMD)
			|| (word == pfp_pkg::READ_NVM_BIT_CMD) || (word == pfp_pkg::READ_SECURE_CMD)
			|| (word == pfp_pkg::get_version_cmd));
	endfunction

	// pin drivers: everything stays an input until the port is active
	always_ff @(posedge i_mclk)
	begin
		if (i_reset || !test_mode)
		begin
			o_port_ready <= 1'b0;
			o_port_ready_oe <= 1'b0;
			o_data_valid_n <= 1'b1;
			o_data_valid_n_oe <= 1'b0;
			o_prog_data_bus <= '0;
			o_prog_data_bus_oe <= 1'b0;
		end
		else
		begin
			o_port_ready_oe <= 1'b1;
			o_data_valid_n_oe <= 1'b1;
			if (latch)
				o_port_ready <= 1'b0;
			else if ((state_reg == pfp_pkg::ST_WAIT_STROBE) && cmd_n_s)
				o_port_ready <= 1'b1;
			if (fifo_pop)
			begin
				o_prog_data_bus <= byte_wide_reg ? {8'h00, fifo_data[7:0]} : fifo_data;
				o_prog_data_bus_oe <= 1'b1;
			end
			else if ((state_reg == pfp_pkg::ST_RD_HOLD) && oe_n_s)
				o_prog_data_bus_oe <= 1'b0;
			if (state_reg == pfp_pkg::ST_RD_DRIVE)
				o_data_valid_n <= 1'b0;
			else if (state_reg == pfp_pkg::ST_RD_REL)
				o_data_valid_n <= 1'b1;
		end
	end

	pfp_fifo #(
		.WIDTH(pfp_pkg::DATA_W),
		.DEPTH(pfp_pkg::FIFO_DEPTH)
	) u_rd_fifo (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_flush(fifo_flush),
		.i_in_valid(i_rd_valid),
		.i_in_data(i_rd_data),
		.o_in_ready(o_rd_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	sequence s_drive_then_valid;
		o_prog_data_bus_oe ##1 !o_data_valid_n;
	endsequence
	sequence s_release_then_valid_high;
		!o_prog_data_bus_oe ##1 o_data_valid_n;
	endsequence

	property p_ready_drop;
		latch |=> !o_port_ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high after strobe");
	property p_ready_rise;
		(state_reg == pfp_pkg::ST_WAIT_STROBE) && cmd_n_s && test_mode |=> o_port_ready;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready not raised");
	property p_bus_busy;
		o_prog_data_bus_oe |-> !o_port_ready;
	endproperty
	a_bus_busy: assert property (p_bus_busy) else $error("bus driven while ready");
	property p_read_drive;
		fifo_pop && test_mode ##1 test_mode |-> s_drive_then_valid;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("valid did not follow drive");
	property p_read_release;
		(state_reg == pfp_pkg::ST_RD_HOLD) && oe_n_s && test_mode ##1 test_mode
			|-> s_release_then_valid_high;
	endproperty
	a_read_release: assert property (p_read_release) else $error("bus not released");
	property p_valid_means_driven;
		!o_data_valid_n |-> o_prog_data_bus_oe || $past(o_prog_data_bus_oe);
	endproperty
	a_valid_means_driven: assert property (p_valid_means_driven) else $error("valid without bus");
	property p_reset_inputs;
		$past(i_reset) |-> !o_port_ready_oe && !o_data_valid_n_oe && !o_prog_data_bus_oe;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset");
	property p_off_quiet;
		!test_mode |=> !o_port_ready_oe && !o_prog_data_bus_oe && (state_reg == pfp_pkg::ST_OFF);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("active outside test mode");
	property p_addr_low;
		latch && (kind_s == pfp_pkg::address_byte_low_mode) |=> addr_reg[7:0] == $past(data_s[7:0]);
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("address byte not loaded");
	property p_idle_kind;
		latch && (kind_s > pfp_pkg::DATA_WORD_MODE) |=> $stable(addr_reg) && $stable(cmd_reg)
			&& !o_cmd_valid;
	endproperty
	a_idle_kind: assert property (p_idle_kind) else $error("idle kind loaded a register");
	property p_erase_exec;
		latch && (kind_s == pfp_pkg::command_word_mode) && (data_s == pfp_pkg::erase_all_cmd)
			|=> o_cmd_valid && (o_cmd_code == pfp_pkg::erase_all_cmd);
	endproperty
	a_erase_exec: assert property (p_erase_exec) else $error("erase all not issued");
	property p_narrow;
		byte_wide_reg |-> o_prog_data_bus[15:8] == 8'h00;
	endproperty
	a_narrow: assert property (p_narrow) else $error("upper byte driven on narrow part");
	property p_clock_frozen;
		first_cmd_seen_reg |=> $stable(o_ext_clock_sel);
	endproperty
	a_clock_frozen: assert property (p_clock_frozen) else $error("clock choice changed");
	property p_strobe_synced;
		latch |-> !$past(i_command_strobe_n, 2);
	endproperty
	a_strobe_synced: assert property (p_strobe_synced) else $error("strobe not synchronised");
endmodule

// >>> test/pfp_prog.sv
// behavioural gang programmer driving the parallel programming pins
module pfp_prog (
	input wire logic i_mclk,
	input wire logic i_ready_pin,
	input wire logic i_valid_n_pin,
	input wire logic [15:0] i_bus_pin,
	output logic [3:0] o_entry,
	output logic o_strobe_n,
	output logic o_oe_n,
	output logic [3:0] o_kind,
	output logic [15:0] o_data,
	output logic o_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	int slow = 0;
	initial
	begin
		o_entry = 4'h0;
		{o_strobe_n, o_oe_n, o_kind, o_data, o_data_oe} = {2'b11, 4'hf, 16'hffff, 1'b0};
	end
	// bounded wait for a pin level; sel 0 is ready, 1 is valid_n
	task automatic wait_pin(input bit sel, input logic lvl, inout logic ok);
		for (int n = 0; n < 300 && ok; n++)
		begin
			@(negedge i_mclk);
			if ((sel ? i_valid_n_pin : i_ready_pin) === lvl)
				return;
		end
		ok = 1'b0;
	endtask
	task automatic enter(input logic [3:0] pins);
		@(negedge i_mclk);
		o_entry = pins;
	endtask
	task automatic start(input logic [3:0] kind, input logic [15:0] data, output logic ok);
		ok = 1'b1;
		@(negedge i_mclk);
		{o_kind, o_data, o_data_oe} = {kind, data, 1'b1};
		repeat (3) @(negedge i_mclk);
		o_strobe_n = 1'b0;
		wait_pin(1'b0, 1'b0, ok);
	endtask
	task automatic close_out(inout logic ok);
		@(negedge i_mclk);
		o_strobe_n = 1'b1;
		wait_pin(1'b0, 1'b1, ok);
		o_kind = 4'hf;
	endtask
	task automatic write_word(input logic [3:0] kind, input logic [15:0] data, output logic ok);
		start(kind, data, ok);
		{o_kind, o_data_oe} = {4'hf, 1'b0};
		close_out(ok);
	endtask
	task automatic read_word(output logic [15:0] data, output logic ok);
		start(4'h5, 16'h0000, ok);
		o_data_oe = 1'b0;
		@(negedge i_mclk);
		o_oe_n = 1'b0;
		wait_pin(1'b1, 1'b0, ok);
		data = i_bus_pin;
		repeat (slow) @(negedge i_mclk);
		o_oe_n = 1'b1;
		wait_pin(1'b1, 1'b1, ok);
		o_data_oe = 1'b1;
		close_out(ok);
		o_data_oe = 1'b0;
	endtask
endmodule

// >>> test/pfp_port_bench.sv
// self-checking bench for the parallel flash programming port
module pfp_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic main_clk_pin = 1'b0;
	logic byte_wide = 1'b0;
	logic cmd_done = 1'b0;
	logic rd_valid = 1'b0;
	logic rdy_seen = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic [15:0] rd_q [$];
	logic [3:0] entry, kind;
	logic strobe_n, oe_n, prog_oe, bus_oe, ready, ready_oe, valid_n, valid_n_oe;
	logic ext_sel, cmd_valid, rd_ready;
	logic [15:0] prog_data, dev_data, cmd_code, cmd_data, last_code, last_data, v;
	logic [31:0] cmd_addr, last_addr;
	int req_cnt = 0;
	int done_cnt = 0;
	int err_total = 0;
	int compares = 0;
	// released pins float high through their pull-ups
	wire logic [15:0] bus_pin = bus_oe ? dev_data : (prog_oe ? prog_data : 16'hffff);
	wire logic ready_pin = ready_oe ? ready : 1'b1;
	wire logic valid_pin = valid_n_oe ? valid_n : 1'b1;
	pfp_prog i_pfp_prog (.i_mclk(mclk), .i_ready_pin(ready_pin), .i_valid_n_pin(valid_pin),
		.i_bus_pin(bus_pin), .o_entry(entry), .o_strobe_n(strobe_n), .o_oe_n(oe_n),
		.o_kind(kind), .o_data(prog_data), .o_data_oe(prog_oe));
	pfp_port i_pfp_port (.i_mclk(mclk), .i_reset(reset), .i_test_select(entry[3]),
		.i_prog_enable_a(entry[2]), .i_prog_enable_b(entry[1]), .i_prog_enable_c(entry[0]),
		.i_main_clock_input(main_clk_pin), .i_byte_wide(byte_wide),
		.i_command_strobe_n(strobe_n), .i_output_enable_n(oe_n), .i_word_kind_select(kind),
		.i_prog_data_bus(bus_pin), .o_prog_data_bus(dev_data), .o_prog_data_bus_oe(bus_oe),
		.o_port_ready(ready), .o_port_ready_oe(ready_oe), .o_data_valid_n(valid_n),
		.o_data_valid_n_oe(valid_n_oe), .o_ext_clock_sel(ext_sel), .o_cmd_valid(cmd_valid),
		.o_cmd_code(cmd_code), .o_cmd_addr(cmd_addr), .o_cmd_data(cmd_data),
		.i_cmd_done(cmd_done), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_rd_ready(rd_ready));
	initial
		forever #5 mclk = ~mclk;
	// flash controller stand-in: logs requests, answers flash and version reads through the fifo
	always @(negedge mclk)
	begin
		if (rd_valid && rdy_seen && rd_q.size() > 0)
			void'(rd_q.pop_front());
		rdy_seen = rd_ready;
		rd_valid = (rd_q.size() > 0);
		rd_data = rd_valid ? rd_q[0] : ~rd_data;
		cmd_done = (done_cnt == 1);
		if (done_cnt > 0)
			done_cnt--;
		if (cmd_valid === 1'b1)
		begin
			req_cnt++;
			{last_code, last_addr, last_data} = {cmd_code, cmd_addr, cmd_data};
			done_cnt = 3;
			if (cmd_code === pfp_pkg::READ_FLASH_CMD || cmd_code === pfp_pkg::get_version_cmd)
				rd_q.push_back(16'h8000 | 16'(req_cnt));
		end
	end
	task automatic finish_test();
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_up(input string what);
		err_total++;
		$display("Error %s expected handshake seen timeout", what);
		finish_test();
	endtask
	task automatic wr(input logic [3:0] k, input logic [15:0] d);
		logic ok;
		i_pfp_prog.write_word(k, d, ok);
		if (ok !== 1'b1)
			give_up("write");
	endtask
	task automatic rd(output logic [15:0] d);
		logic ok;
		i_pfp_prog.read_word(d, ok);
		if (ok !== 1'b1)
			give_up("read");
	endtask
	task automatic do_reset();
		reset = 1'b1;
		repeat (6) @(negedge mclk);
		reset = 1'b0;
	endtask
	task automatic wait_ready();
		int n = 0;
		while (!(ready_oe === 1'b1 && ready === 1'b1) && n < 100)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 100)
			give_up("ready after entry");
	endtask
	task automatic t_reset_state();
		check("bus oe", 0, bus_oe);
		check("ready oe", 0, ready_oe);
		check("valid oe", 0, valid_n_oe);
		check("fifo ready", 1, rd_ready);
		i_pfp_prog.enter(4'b1111);
		repeat (10) @(negedge mclk);
		check("ready oe wrong entry", 0, ready_oe);
		i_pfp_prog.enter(4'b1110);
		wait_ready();
		check("valid idle", 1, valid_pin);
		check("bus oe idle", 0, bus_oe);
	endtask
	task automatic t_commands();
		logic [15:0] codes [4] = '{pfp_pkg::erase_all_cmd, pfp_pkg::set_lock_cmd,
			pfp_pkg::WRITE_PAGE_CMD, pfp_pkg::CLEAR_LOCK_CMD};
		int n;
		foreach (codes[i])
		begin
			n = req_cnt;
			wr(pfp_pkg::command_word_mode, codes[i]);
			check("request count", n + 1, req_cnt);
			check("request code", codes[i], last_code);
			check("ready after", 1, ready);
		end
		wr(pfp_pkg::command_word_mode, pfp_pkg::get_version_cmd);
		check("read kind stored", n + 1, req_cnt);
		rd(v);
		check("version word", 16'h8000 | 16'(req_cnt), v);
		check("version code", pfp_pkg::get_version_cmd, last_code);
	endtask
	task automatic t_address_idle();
		int n;
		wr(pfp_pkg::command_word_mode, pfp_pkg::WRITE_PAGE_CMD);
		wr(pfp_pkg::address_byte_low_mode, 16'hab11);
		wr(pfp_pkg::ADDR_BYTE1_MODE, 16'hcd22);
		wr(pfp_pkg::ADDR_BYTE2_MODE, 16'hef33);
		wr(pfp_pkg::ADDR_BYTE3_MODE, 16'h0144);
		n = req_cnt;
		for (int k = 6; k < 16; k++)
			wr(4'(k), 16'h00ff);
		check("idle requests", n, req_cnt);
		wr(pfp_pkg::DATA_WORD_MODE, 16'h1234);
		check("data requests", n + 1, req_cnt);
		check("data addr", 32'h44332211, last_addr);
		check("data word", 16'h1234, last_data);
		check("data code", pfp_pkg::WRITE_PAGE_CMD, last_code);
	endtask
	task automatic t_read_fifo();
		wr(pfp_pkg::command_word_mode, pfp_pkg::READ_FLASH_CMD);
		wr(pfp_pkg::address_byte_low_mode, 16'h0040);
		wr(pfp_pkg::ADDR_BYTE1_MODE, 16'h0000);
		@(posedge mclk);
		for (int i = 0; i < 5; i++)
			rd_q.push_back(16'h1000 + 16'(i));
		repeat (10) @(negedge mclk);
		check("fifo full", 0, rd_ready);
		check("refused words", 1, rd_q.size());
		i_pfp_prog.slow = 6;
		for (int i = 0; i < 5; i++)
		begin
			rd(v);
			check("read word", 16'h1000 + 16'(i), v);
			check("read code", pfp_pkg::READ_FLASH_CMD, last_code);
			check("bus released", 0, bus_oe);
		end
		i_pfp_prog.slow = 0;
	endtask
	task automatic t_reenter();
		i_pfp_prog.enter(4'b0110);
		repeat (4) @(negedge mclk);
		check("ready oe off", 0, ready_oe);
		check("bus oe off", 0, bus_oe);
		check("ext clock held", 0, ext_sel);
		@(posedge mclk);
		rd_q.delete();
		@(negedge mclk);
		byte_wide = 1'b1;
		do_reset();
		repeat (6) @(negedge mclk) main_clk_pin = ~main_clk_pin;
		i_pfp_prog.enter(4'b1110);
		wait_ready();
		wr(pfp_pkg::command_word_mode, pfp_pkg::READ_FLASH_CMD);
		check("ext clock", 1, ext_sel);
		rd(v);
		check("narrow word", {8'h00, 8'(req_cnt)}, v);
	endtask
	initial
	begin
		do_reset();
		t_reset_state();
		t_commands();
		t_address_idle();
		t_read_fifo();
		t_reenter();
		finish_test();
	end
endmodule
